// File: eeprom_slave.sv
`timescale 1ns/10ps
`default_nettype none
module eeprom_slave #(
  // arbitrary device type value
  parameter logic [3:0] DEV_TYPE = 4'h6,
  parameter int LOCK_CYCLES = eeprom_pkg::LOCK_CYCLES,
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  // system
  input wire logic clk,
  input wire logic rst_b,
  // supply sense comparator
  input wire logic supply_above_lock,
  // two-wire link
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // status
  output eeprom_pkg::status_s status
);

  localparam int CW = eeprom_pkg::CNT_W;

  eeprom_pkg::core_s st_q;
  eeprom_pkg::core_s st_d;
  eeprom_pkg::link_s lk_q;
  eeprom_pkg::link_s lk_d;

  logic [7:0] mem [eeprom_pkg::MEM_WORDS];
  logic [7:0] page_buf [eeprom_pkg::PAGE_BYTES];

  logic start_tog_q;
  logic stop_tog_q;
  logic rst_m_q;
  logic rst_s_q;
  logic sda_oe_q;
  logic sda_out_q;
  logic commit;
  logic lock_now;
  logic drv;
  logic buf_wr;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b);
    return {sh[6:0], b};
  endfunction

  // conditions on the bus are caught by the data line itself
  always_ff @(negedge sda_in) begin
    if (!rst_b) begin
      start_tog_q <= 1'b0;
    end else if (scl) begin
      start_tog_q <= ~start_tog_q;
    end
  end

  always_ff @(posedge sda_in) begin
    if (!rst_b) begin
      stop_tog_q <= 1'b0;
    end else if (scl) begin
      stop_tog_q <= ~stop_tog_q;
    end
  end

  // reset carried into the link domain
  always_ff @(posedge scl) begin
    rst_m_q <= rst_b;
    rst_s_q <= rst_m_q;
  end

  // core domain: supply lockout and write cycle
  always_comb begin
    st_d = st_q;
    st_d.sup_m = supply_above_lock;
    st_d.sup_s = st_q.sup_m;
    st_d.stop_m = stop_tog_q;
    st_d.stop_s = st_q.stop_m;
    st_d.stop_p = st_q.stop_s;
    st_d.pend_m = lk_q.pend;
    st_d.pend_s = st_q.pend_m;
    lock_now = !st_q.sup_s || (st_q.lock_cnt != eeprom_pkg::CNT_ZERO);
    // any dip restarts the full hold-off
    if (!st_q.sup_s) begin
      st_d.lock_cnt = CW'(LOCK_CYCLES - 1);
    end else if (st_q.lock_cnt != eeprom_pkg::CNT_ZERO) begin
      st_d.lock_cnt = st_q.lock_cnt - 1'b1;
    end
    st_d.locked = lock_now;
    // stop launches the write unless locked out
    commit = (st_q.stop_s != st_q.stop_p) && st_q.pend_s
             && !lock_now && !st_q.busy;
    if (commit) begin
      st_d.busy = 1'b1;
      st_d.wcnt = CW'(WRITE_CYCLES - 1);
    end else if (st_q.busy) begin
      if (st_q.wcnt == eeprom_pkg::CNT_ZERO) begin
        st_d.busy = 1'b0;
      end else begin
        st_d.wcnt = st_q.wcnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.locked <= 1'b1;
      st_q.lock_cnt <= CW'(LOCK_CYCLES - 1);
    end else begin
      st_q <= st_d;
    end
  end

  // page and address are quiet once stop is seen, so read directly
  always_ff @(posedge clk) begin
    for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
      if (commit && lk_q.mask[i]) begin
        mem[{lk_q.ptr[8:4], 4'(i)}] <= page_buf[i];
      end
    end
  end

  assign status = '{busy: st_q.busy, locked: st_q.locked};

  // link domain: bits sampled on the rising clock edge
  assign byte_in = shift_in(lk_q.sh, sda_in);
  // array stays still while reads are allowed
  assign rd_byte = mem[lk_q.ptr];

  always_comb begin
    lk_d = lk_q;
    buf_wr = 1'b0;
    lk_d.busy_m = st_q.busy;
    lk_d.busy_s = lk_q.busy_m;
    if (start_tog_q != lk_q.st_seen) begin
      lk_d.st_seen = start_tog_q;
      lk_d.sp_seen = stop_tog_q;
      lk_d.st = eeprom_pkg::L_DEV;
      lk_d.sh = byte_in;
      lk_d.cnt = eeprom_pkg::BIT_FIRST;
      lk_d.pend = 1'b0;
      lk_d.mask = '0;
    end else if (stop_tog_q != lk_q.sp_seen) begin
      lk_d.sp_seen = stop_tog_q;
      lk_d.st = eeprom_pkg::L_IDLE;
      lk_d.cnt = 4'h0;
    end else begin
      case (lk_q.st)
        eeprom_pkg::L_DEV, eeprom_pkg::L_WADR, eeprom_pkg::L_WDAT: begin
          if (lk_q.cnt != eeprom_pkg::ACK_SLOT) begin
            lk_d.sh = byte_in;
            lk_d.cnt = lk_q.cnt + 1'b1;
            if (lk_q.cnt == eeprom_pkg::BIT_LAST) begin
              lk_d.ackf = 1'b1;
              if (lk_q.st == eeprom_pkg::L_DEV) begin
                // bits 3:2 take no part in the match
                lk_d.ackf = (byte_in[7:4] == DEV_TYPE)
                            && !lk_q.busy_s;
                // other devices' traffic leaves the bank alone
                if (!byte_in[0] && (byte_in[7:4] == DEV_TYPE)) begin
                  lk_d.ptr[8] = byte_in[1];
                end
              end else if (lk_q.st == eeprom_pkg::L_WADR) begin
                lk_d.ptr[7:0] = byte_in;
              end else begin
                buf_wr = 1'b1;
                lk_d.mask[lk_q.ptr[3:0]] = 1'b1;
                lk_d.pend = 1'b1;
                lk_d.ptr[3:0] = lk_q.ptr[3:0] + 1'b1;
              end
            end
          end else begin
            lk_d.cnt = 4'h0;
            if (!lk_q.ackf) begin
              lk_d.st = eeprom_pkg::L_HOLD;
            end else if (lk_q.st == eeprom_pkg::L_DEV) begin
              lk_d.st = lk_q.sh[0] ? eeprom_pkg::L_RDAT
                                   : eeprom_pkg::L_WADR;
            end else begin
              lk_d.st = eeprom_pkg::L_WDAT;
            end
          end
        end
        eeprom_pkg::L_RDAT: begin
          if (lk_q.cnt != eeprom_pkg::ACK_SLOT) begin
            lk_d.cnt = lk_q.cnt + 1'b1;
          end else begin
            lk_d.cnt = 4'h0;
            lk_d.ptr = lk_q.ptr + 1'b1;
            if (sda_in) begin
              lk_d.st = eeprom_pkg::L_HOLD;
            end
          end
        end
        default: begin
          lk_d.cnt = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge scl) begin
    if (!rst_s_q) begin
      lk_q <= '0;
      lk_q.st_seen <= 1'b0;
      lk_q.sp_seen <= 1'b0;
      lk_q.ptr <= eeprom_pkg::PTR_RESET;
    end else begin
      lk_q <= lk_d;
    end
  end

  always_ff @(posedge scl) begin
    if (buf_wr) begin
      page_buf[lk_q.ptr[3:0]] <= byte_in;
    end
  end

  // drive decision follows the state left by the last rise
  always_comb begin
    drv = 1'b0;
    case (lk_q.st)
      eeprom_pkg::L_DEV, eeprom_pkg::L_WADR, eeprom_pkg::L_WDAT: begin
        drv = (lk_q.cnt == eeprom_pkg::ACK_SLOT) && lk_q.ackf;
      end
      eeprom_pkg::L_RDAT: begin
        drv = (lk_q.cnt != eeprom_pkg::ACK_SLOT)
              && !rd_byte[3'h7 - lk_q.cnt[2:0]];
      end
      default: begin
        drv = 1'b0;
      end
    endcase
  end

  // open drain: only ever pulls low, changes on the falling edge
  always_ff @(negedge scl) begin
    if (!rst_s_q) begin
      sda_oe_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else begin
      sda_oe_q <= drv;
      sda_out_q <= 1'b0;
    end
  end

  assign sda_oe = sda_oe_q;
  assign sda_out = sda_out_q;

  // core domain checks
  property p_lock_low;
    @(posedge clk) disable iff (!rst_b)
    !st_q.sup_s |-> !commit;
  endproperty
  a_lock_low: assert property (p_lock_low)
    else $error("write launched below supply threshold");

  property p_holdoff;
    @(posedge clk) disable iff (!rst_b)
    $rose(st_q.sup_s) |-> st_q.lock_cnt == CW'(LOCK_CYCLES - 1)
      ##1 status.locked;
  endproperty
  a_holdoff: assert property (p_holdoff)
    else $error("hold-off not restarted after supply return");

  property p_commit_time;
    @(posedge clk) disable iff (!rst_b)
    commit |=> st_q.busy && st_q.wcnt == CW'(WRITE_CYCLES - 1);
  endproperty
  a_commit_time: assert property (p_commit_time)
    else $error("write cycle not loaded on commit");

  property p_busy_end;
    @(posedge clk) disable iff (!rst_b)
    st_q.busy && st_q.wcnt == eeprom_pkg::CNT_ZERO |=> !st_q.busy;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("write cycle overran its count");

  // link domain checks
  property p_busy_nack;
    @(posedge scl) disable iff (!rst_s_q)
    lk_q.busy_s && lk_q.st == eeprom_pkg::L_DEV
      && lk_q.cnt == eeprom_pkg::BIT_LAST
      && start_tog_q == lk_q.st_seen
      && stop_tog_q == lk_q.sp_seen |=> !lk_q.ackf;
  endproperty
  a_busy_nack: assert property (p_busy_nack)
    else $error("address acknowledged while busy");

  property p_id_match;
    @(posedge scl) disable iff (!rst_s_q)
    lk_q.st == eeprom_pkg::L_DEV && lk_q.cnt == eeprom_pkg::ACK_SLOT
      && lk_q.ackf |-> lk_q.sh[7:4] == DEV_TYPE && sda_oe;
  endproperty
  a_id_match: assert property (p_id_match)
    else $error("ack without type match");

  property p_page_wrap;
    @(posedge scl) disable iff (!rst_s_q)
    buf_wr |=> lk_q.ptr[8:4] == $past(lk_q.ptr[8:4])
      && lk_q.ptr[3:0] == $past(lk_q.ptr[3:0]) + 4'h1;
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("page pointer left its page");

  property p_read_inc;
    @(posedge scl) disable iff (!rst_s_q)
    lk_q.st == eeprom_pkg::L_RDAT && lk_q.cnt == eeprom_pkg::ACK_SLOT
      && start_tog_q == lk_q.st_seen && stop_tog_q == lk_q.sp_seen
      |=> lk_q.ptr == $past(lk_q.ptr) + 9'h001;
  endproperty
  a_read_inc: assert property (p_read_inc)
    else $error("read pointer not advanced");

  property p_read_nack;
    @(posedge scl) disable iff (!rst_s_q)
    lk_q.st == eeprom_pkg::L_RDAT && lk_q.cnt == eeprom_pkg::ACK_SLOT
      && sda_in && start_tog_q == lk_q.st_seen
      && stop_tog_q == lk_q.sp_seen |=> lk_q.st == eeprom_pkg::L_HOLD;
  endproperty
  a_read_nack: assert property (p_read_nack)
    else $error("kept sending after no acknowledge");

  property p_read_bit;
    @(posedge scl) disable iff (!rst_s_q)
    lk_q.st == eeprom_pkg::L_RDAT && lk_q.cnt != eeprom_pkg::ACK_SLOT
      |-> sda_oe == !rd_byte[3'h7 - lk_q.cnt[2:0]];
  endproperty
  a_read_bit: assert property (p_read_bit)
    else $error("read bit wrong at clock rise");

  c_commit: cover property (@(posedge clk) disable iff (!rst_b) commit);
  c_poll_nack: cover property (@(posedge scl) disable iff (!rst_s_q)
    lk_q.busy_s && lk_q.st == eeprom_pkg::L_HOLD);
  c_seq_read: cover property (@(posedge scl) disable iff (!rst_s_q)
    lk_q.st == eeprom_pkg::L_RDAT && lk_q.cnt == eeprom_pkg::ACK_SLOT
    && !sda_in);
  c_page_wrap: cover property (@(posedge scl) disable iff (!rst_s_q)
    buf_wr && lk_q.mask[lk_q.ptr[3:0]]);

endmodule // eeprom_slave
`default_nettype wire

// File: eeprom_pkg.sv
`default_nettype none
package eeprom_pkg;
  // system clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int LOCK_TIME_MS = 200;
  localparam int LOCK_CYCLES = LOCK_TIME_MS * 1000000 / CLK_PERIOD_NS;
  // default nonvolatile_write_time, held as a top parameter
  localparam int WRITE_TIME_US = 5000;
  localparam int WRITE_CYCLES = WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
  // array geometry
  localparam int MEM_WORDS = 512;
  localparam int PAGE_BYTES = 16;
  // bit counter positions within one nine-clock slot
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // reset values
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [8:0] PTR_RESET = 9'h000;

  typedef enum logic [2:0] {
    L_IDLE = 3'h0,
    L_DEV = 3'h1,
    L_WADR = 3'h2,
    L_WDAT = 3'h3,
    L_RDAT = 3'h4,
    L_HOLD = 3'h5
  } link_state_e;

  typedef struct packed {
    link_state_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic ackf;
    logic [8:0] ptr;
    logic [15:0] mask;
    logic pend;
    logic st_seen;
    logic sp_seen;
    logic busy_m;
    logic busy_s;
  } link_s;

  typedef struct packed {
    logic sup_m;
    logic sup_s;
    logic stop_m;
    logic stop_s;
    logic stop_p;
    logic pend_m;
    logic pend_s;
    logic [CNT_W-1:0] lock_cnt;
    logic [CNT_W-1:0] wcnt;
    logic busy;
    logic locked;
  } core_s;

  typedef struct packed {
    logic busy;
    logic locked;
  } status_s;
endpackage
`default_nettype wire

// File: dummy_end_marker_unused.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: tw_master.sv
`timescale 1ns/10ps
`default_nettype none
module tw_master (
  // link
  output logic scl,
  output logic sda_m,
  input wire logic sda_w
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // data only moves with scl low, so no false start or stop
  task automatic clk_bit(input logic v, output logic s);
    #10 sda_m = v;
    #30 scl = 1'b1;
    #20 s = sda_w;
    #20 scl = 1'b0;
  endtask
  task automatic start;
    #10 sda_m = 1'b1;
    #30 scl = 1'b1;
    #40 sda_m = 1'b0;
    #40 scl = 1'b0;
  endtask
  // bus left free long enough for the stop to reach the core
  task automatic stop;
    #10 sda_m = 1'b0;
    #30 scl = 1'b1;
    #40 sda_m = 1'b1;
    #600;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(~ack, s);
  endtask
  // bare clock pulses, data held high
  task automatic pulses(input int n);
    repeat (n) begin
      #40 scl = 1'b0;
      #40 scl = 1'b1;
    end
  endtask
  task automatic rst_seq;
    pulses(3);
    #40 sda_m = 1'b0;
    #40 sda_m = 1'b1;
  endtask
endmodule // tw_master
`default_nettype wire

// File: two_wire_eeprom_slave_with_write_lockout_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module two_wire_eeprom_slave_with_write_lockout_tb_top;
  localparam logic [3:0] dev_type = 4'h5; // arbitrary value
  localparam int lock_n = 60;
  localparam int wr_n = 40;
  logic clk, rst_b, supply_above_lock, scl, sda_m, sda_w, sda_out, sda_oe, saw_busy;
  eeprom_pkg::status_s status;
  logic [7:0] mem [512];
  logic [8:0] a9;
  logic ack;
  int fails, compares, cyc, n;
  // open drain wire with pull-up
  assign sda_w = sda_m & ~(sda_oe & ~sda_out);
  eeprom_slave #(.DEV_TYPE(dev_type), .LOCK_CYCLES(lock_n), .WRITE_CYCLES(wr_n)) u_eeprom_slave (
    .clk(clk), .rst_b(rst_b), .supply_above_lock(supply_above_lock), .scl(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .status(status));
  tw_master u_tw_master (.scl(scl), .sda_m(sda_m), .sda_w(sda_w));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (status.busy === 1'b1) saw_busy <= 1'b1;
    if (cyc == 30000) begin
      fails++;
      close_out;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] adr(input logic bank, input logic rw);
    adr = {dev_type, 2'($urandom), bank, rw};
  endfunction
  task automatic write_page(input logic [8:0] a, input int cnt, input logic commit);
    logic [7:0] d;
    int k;
    u_tw_master.start();
    u_tw_master.wbyte(adr(a[8], 1'b0), ack);
    chk(ack, 1'b1);
    u_tw_master.wbyte(a[7:0], ack);
    chk(ack, 1'b1);
    for (k = 0; k < cnt; k++) begin
      d = 8'($urandom);
      u_tw_master.wbyte(d, ack);
      chk(ack, 1'b1);
      if (commit) mem[{a[8:4], a[3:0] + 4'(k)}] = d;
    end
    saw_busy = 1'b0;
    u_tw_master.stop();
    k = 0;
    // poll with write address until answered
    do begin
      u_tw_master.start();
      u_tw_master.wbyte(adr(1'b0, 1'b0), ack);
      u_tw_master.stop();
      if (k == 0) chk(ack, !commit);
      k++;
    end while (!ack && k < 40);
    chk(ack, 1'b1);
    chk(saw_busy, commit);
  endtask
  task automatic cur_read(input logic [8:0] a, input int cnt);
    logic [7:0] d;
    u_tw_master.start();
    u_tw_master.wbyte(adr(1'($urandom), 1'b1), ack);
    chk(ack, 1'b1);
    for (int k = 0; k < cnt; k++) begin
      u_tw_master.rbyte(k < cnt - 1, d);
      chk(d, mem[a + 9'(k)]);
    end
    u_tw_master.stop();
    chk(sda_oe, 1'b0);
  endtask
  task automatic read_seq(input logic [8:0] a, input int cnt);
    u_tw_master.start();
    u_tw_master.wbyte(adr(a[8], 1'b0), ack);
    chk(ack, 1'b1);
    u_tw_master.wbyte(a[7:0], ack);
    chk(ack, 1'b1);
    cur_read(a, cnt);
  endtask
  initial begin
    void'($urandom(32'hfadb01c6));
    {rst_b, supply_above_lock, saw_busy} = 3'h0;
    fails = 0;
    compares = 0;
    cyc = 0;
    u_tw_master.rst_seq();
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    // link leaves reset only on scl edges, so give it some before a start
    u_tw_master.pulses(3);
    repeat (3) @(posedge clk);
    chk(status.locked, 1'b1);
    supply_above_lock <= 1'b1;
    // writes dropped while held off; array still empty, so no read here
    fork
      begin
        n = 0;
        while (status.locked !== 1'b0 && n < 200) begin
          @(posedge clk);
          n++;
        end
      end
      begin
        write_page(9'h0a5, 1, 1'b0);
      end
    join
    chk(n >= lock_n && n <= lock_n + 5, 1'b1);
    write_page(9'h1ff, 1, 1'b1);
    write_page(9'h000, 2, 1'b1);
    read_seq(9'h1ff, 2);
    cur_read(9'h001, 1);
    a9 = {5'($urandom), 4'he};
    write_page(a9, 18, 1'b1);
    read_seq({a9[8:4], 4'h0}, 16);
    repeat (3) begin
      a9 = {5'($urandom), 4'($urandom_range(12))};
      n = $urandom_range(4, 1);
      write_page(a9, n, 1'b1);
      read_seq(a9, n);
    end
    u_tw_master.start();
    u_tw_master.wbyte({dev_type ^ 4'h3, 4'h0}, ack);
    chk(ack, 1'b0);
    u_tw_master.stop();
    // supply drop must not disturb stored data
    @(posedge clk) supply_above_lock <= 1'b0;
    repeat (4) @(posedge clk);
    chk(status.locked, 1'b1);
    write_page(a9, 1, 1'b0);
    @(posedge clk) supply_above_lock <= 1'b1;
    // reads served on stored data inside the hold-off
    read_seq(a9, 1);
    chk(status.locked, 1'b1);
    repeat (lock_n + 10) @(posedge clk);
    read_seq(a9, 1);
    close_out;
  end
endmodule // two_wire_eeprom_slave_with_write_lockout_tb_top
`default_nettype wire
